// ---- logic/usp_defs.svh ----
`ifndef USP_DEFS_SVH
`define USP_DEFS_SVH
// Function
// - clear master-source bit: clock from pin
// - shifting works while the core sleeps
// - slave paths match master transmit/receive behaviour
// - first word moves to shifter at once
// - second word waits; empty flag stays clear
// - after shift-out, reload then set empty flag
// - tx interrupt enable wakes sleeping chip
// - software sets mode, port enable, clears receives
// - nine-bit transmit sends the preloaded ninth bit
// - transmit enable plus buffer write starts sending
// - single-receive enable ignored in slave mode
// - continuous receive keeps accepting during sleep
// - finished word moves to holding buffer, wakes
// - nine-bit receive; ninth bit, errors readable
// - receive-complete flag set, interrupt if enabled
// - data read returns the oldest completed word
// - clearing continuous receive clears reception errors

// register byte offsets
`define USP_OFS_TSC      8'h00
`define USP_OFS_RSC      8'h04
`define USP_OFS_TXB      8'h08
`define USP_OFS_RXB      8'h0C
`define USP_OFS_IST      8'h10
`define USP_OFS_IMSK     8'h14
// tx_status_control fields
`define USP_TSC_SHIFT_SOURCE_MASTER_BIT     7
`define USP_TSC_TX9      6
`define USP_TSC_TRANSMIT_ENABLE     5
`define USP_TSC_SYNC     4
`define USP_TSC_SHEMPTY  2
`define USP_TSC_BUFEMPTY 1
`define USP_TSC_TX_NINTH_BIT     0
// rx_status_control fields
`define USP_RSC_PORT_ENABLE     7
`define USP_RSC_RX9      6
`define USP_RSC_SINGLE_RECEIVE_ENABLE     5
`define USP_RSC_CONTINUOUS_RECEIVE_ENABLE     4
`define USP_RSC_AVAIL    2
`define USP_RSC_OERR     1
`define USP_RSC_RX9D     0
// event status / mask fields, control reset value, bus response codes
`define USP_EV_TX        0
`define USP_EV_RX        1
`define USP_CTL_RESET    8'h00
`define USP_RESP_OKAY    2'h0
`define USP_RESP_SLVERR  2'h2
// word lengths and receive buffer depth
`define USP_BITS8        4'h8
`define USP_BITS9        4'h9
`define USP_RX_DEPTH     2'h2
// link timing
`define USP_CLK_PERIOD_NS  20
`define USP_LINK_PERIOD_NS 160
`define USP_HALF_CYCLES \
   (`USP_LINK_PERIOD_NS / (2 * `USP_CLK_PERIOD_NS))
`endif

// ---- logic/usp_pkg.sv ----
package usp_pkg;
   typedef enum logic [1:0] {USP_M_IDLE, USP_M_LOW, USP_M_HIGH}
      usp_mst_state_t;
   typedef logic [8:0] usp_word_t;
endpackage : usp_pkg

// ---- logic/usp_link_if.sv ----
`timescale 1ns/1ps
interface usp_link_if;
   logic ck;
   logic dt_dev_o;
   logic dt_dev_oe;
   logic dt_mst_o;
   logic dt_mst_oe;
   wire  dt;
   // pulled high when nobody drives
   assign dt = dt_dev_oe ? dt_dev_o : (dt_mst_oe ? dt_mst_o : 1'b1);
   modport device (input ck, input dt, output dt_dev_o, output dt_dev_oe);
   modport master (output ck, output dt_mst_o, output dt_mst_oe,
                   input dt);
endinterface : usp_link_if

// ---- logic/usp_master.sv ----
`timescale 1ns/1ps
`include "usp_defs.svh"
module usp_master #(
   parameter logic [7:0] HALF = 8'(`USP_HALF_CYCLES)
) (
   input  wire logic            aclk,
   input  wire logic            aresetn,
   usp_link_if.master           lnk,
   input  wire logic            start,
   input  wire logic            write_mode,
   input  wire logic            nine_bits,
   input  wire usp_pkg::usp_word_t tx_word,
   output logic                 busy,
   output logic                 done,
   output usp_pkg::usp_word_t   rx_word
);
   usp_pkg::usp_mst_state_t state;
   logic [7:0] cnt;
   logic [3:0] left;
   logic [8:0] sh;
   logic [8:0] rxsh;
   logic [8:0] next_rx;
   logic       n9;
   logic       drv;
   logic       ck;
   logic [1:0] dt_sync;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         dt_sync <= 2'h3;
      else
         dt_sync <= {dt_sync[0], lnk.dt};
   end

   assign next_rx = {dt_sync[1], rxsh[8:1]};

   // this end makes the link clock by dividing its own clock
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state   <= usp_pkg::USP_M_IDLE;
         cnt     <= 8'h00;
         left    <= 4'h0;
         sh      <= 9'h000;
         rxsh    <= 9'h000;
         n9      <= 1'b0;
         drv     <= 1'b0;
         ck      <= 1'b0;
         done    <= 1'b0;
         rx_word <= 9'h000;
      end
      else
      begin
         done <= 1'b0;
         unique case (state)
            usp_pkg::USP_M_IDLE:
               if (start)
               begin
                  sh    <= tx_word;
                  drv   <= write_mode;
                  n9    <= nine_bits;
                  left  <= nine_bits ? `USP_BITS9 : `USP_BITS8;
                  cnt   <= 8'h00;
                  state <= usp_pkg::USP_M_LOW;
               end
            usp_pkg::USP_M_LOW:
               if (cnt == HALF - 8'h01)
               begin
                  cnt   <= 8'h00;
                  ck    <= 1'b1;
                  state <= usp_pkg::USP_M_HIGH;
               end
               else
                  cnt <= cnt + 8'h01;
            usp_pkg::USP_M_HIGH:
               // sample late in the high phase: covers the far end's
               // synchroniser delay before its data change
               if (cnt == HALF - 8'h01)
               begin
                  cnt  <= 8'h00;
                  ck   <= 1'b0;
                  rxsh <= next_rx;
                  sh   <= {1'b0, sh[8:1]};
                  if (left == 4'h1)
                  begin
                     state   <= usp_pkg::USP_M_IDLE;
                     drv     <= 1'b0;
                     done    <= 1'b1;
                     rx_word <= n9 ? next_rx : {1'b0, next_rx[8:1]};
                  end
                  else
                  begin
                     left  <= left - 4'h1;
                     state <= usp_pkg::USP_M_LOW;
                  end
               end
               else
                  cnt <= cnt + 8'h01;
         endcase
      end
   end

   assign busy          = (state != usp_pkg::USP_M_IDLE);
   assign lnk.ck        = ck;
   assign lnk.dt_mst_o  = sh[0];
   assign lnk.dt_mst_oe = drv;
endmodule : usp_master

// ---- logic/usp_device.sv ----
`timescale 1ns/1ps
`include "usp_defs.svh"
module usp_device (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   input  wire logic        core_sleep,
   output logic             irq,
   output logic             core_wake,
   usp_link_if.device       lnk
);
   logic [7:0] tsc;
   logic [7:0] rsc;
   logic [1:0] ev_status;
   logic [1:0] ev_mask;
   logic       aw_got;
   logic       w_got;
   logic [7:0] aw_addr;
   logic [7:0] w_byte;
   logic       w_lane0;
   logic       do_write;
   logic       wr_hit;
   logic [1:0] ck_sync;
   logic [1:0] dt_sync;
   logic       ck_prev;
   logic       ck_rise;
   logic       ck_fall;
   logic       slave_on;
   logic       rx_on;
   logic [8:0] tx_hold;
   logic       tx_full;
   logic [8:0] tx_shift;
   logic [3:0] tx_cnt;
   logic       tx_busy;
   logic       tx_load;
   logic [8:0] rx_shift;
   logic [3:0] rx_cnt;
   logic [8:0] next_rx;
   logic       rx_push;
   logic       rx_pop;
   logic [8:0] rx_mem [2];
   logic       wr_idx;
   logic       rd_idx;
   logic [1:0] rx_count;
   logic       oerr;
   logic [7:0] rd_val;
   logic       rd_map;

   // bus write: address and data taken in either order
   assign awready  = !aw_got;
   assign wready   = !w_got;
   assign do_write = aw_got && w_got && !bvalid;
   assign wr_hit   = do_write && w_lane0;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_got  <= 1'b0;
         w_got   <= 1'b0;
         aw_addr <= 8'h00;
         w_byte  <= 8'h00;
         w_lane0 <= 1'b0;
         bvalid  <= 1'b0;
         bresp   <= `USP_RESP_OKAY;
      end
      else
      begin
         if (awvalid && awready)
         begin
            aw_got  <= 1'b1;
            aw_addr <= awaddr;
         end
         if (wvalid && wready)
         begin
            w_got   <= 1'b1;
            w_byte  <= wdata[7:0];
            w_lane0 <= wstrb[0];
         end
         if (do_write)
         begin
            aw_got <= 1'b0;
            w_got  <= 1'b0;
            bvalid <= 1'b1;
            bresp  <= (aw_addr == `USP_OFS_TSC || aw_addr == `USP_OFS_RSC
                       || aw_addr == `USP_OFS_TXB
                       || aw_addr == `USP_OFS_IST
                       || aw_addr == `USP_OFS_IMSK)
                      ? `USP_RESP_OKAY : `USP_RESP_SLVERR;
         end
         else if (bvalid && bready)
            bvalid <= 1'b0;
      end
   end

   // control registers; status bits are merged on read
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         tsc     <= `USP_CTL_RESET;
         rsc     <= `USP_CTL_RESET;
         ev_mask <= 2'h0;
      end
      else if (wr_hit)
      begin
         if (aw_addr == `USP_OFS_TSC)
            tsc <= w_byte;
         if (aw_addr == `USP_OFS_RSC)
            rsc <= w_byte;
         if (aw_addr == `USP_OFS_IMSK)
            ev_mask <= w_byte[1:0];
      end
   end

   // master-source bit set means internal clocking, not built here
   assign slave_on = rsc[`USP_RSC_PORT_ENABLE] && tsc[`USP_TSC_SYNC]
                     && !tsc[`USP_TSC_SHIFT_SOURCE_MASTER_BIT];
   // single-receive enable deliberately unused in slave mode
   assign rx_on    = slave_on && rsc[`USP_RSC_CONTINUOUS_RECEIVE_ENABLE];

   // link pins cross into aclk through two flops
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ck_sync <= 2'h0;
         dt_sync <= 2'h3;
         ck_prev <= 1'b0;
      end
      else
      begin
         ck_sync <= {ck_sync[0], lnk.ck};
         dt_sync <= {dt_sync[0], lnk.dt};
         ck_prev <= ck_sync[1];
      end
   end

   assign ck_rise = ck_sync[1] && !ck_prev;
   assign ck_fall = !ck_sync[1] && ck_prev;

   // no gating on core_sleep: the shifter runs on the outside clock
   // and transmit/receive never look at sleep
   assign tx_load = slave_on && tsc[`USP_TSC_TRANSMIT_ENABLE]
                    && !rsc[`USP_RSC_CONTINUOUS_RECEIVE_ENABLE] && tx_full
                    && !tx_busy;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         tx_hold <= 9'h000;
         tx_full <= 1'b0;
      end
      else
      begin
         if (tx_load)
            tx_full <= 1'b0;
         // a write overwrites an unsent word; the ninth bit is taken now
         if (wr_hit && aw_addr == `USP_OFS_TXB)
         begin
            tx_hold <= {tsc[`USP_TSC_TX_NINTH_BIT], w_byte};
            tx_full <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         tx_shift <= 9'h000;
         tx_cnt   <= 4'h0;
         tx_busy  <= 1'b0;
      end
      else if (!slave_on || !tsc[`USP_TSC_TRANSMIT_ENABLE])
         tx_busy <= 1'b0;
      else if (tx_load)
      begin
         tx_shift <= tx_hold;
         tx_cnt   <= tsc[`USP_TSC_TX9] ? `USP_BITS9 : `USP_BITS8;
         tx_busy  <= 1'b1;
      end
      else if (tx_busy && ck_fall)
      begin
         tx_shift <= {1'b0, tx_shift[8:1]};
         tx_cnt   <= tx_cnt - 4'h1;
         if (tx_cnt == 4'h1)
            tx_busy <= 1'b0;
      end
   end

   assign lnk.dt_dev_o  = tx_shift[0];
   assign lnk.dt_dev_oe = tx_busy;

   // receive: sample on each detected rising edge, LSB first
   assign next_rx = {dt_sync[1], rx_shift[8:1]};
   assign rx_push = rx_on && ck_rise
                    && (rx_cnt == (rsc[`USP_RSC_RX9] ? `USP_BITS9
                                                   : `USP_BITS8) - 4'h1);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rx_shift <= 9'h000;
         rx_cnt   <= 4'h0;
      end
      else if (!rx_on)
         rx_cnt <= 4'h0;
      else if (ck_rise)
      begin
         rx_shift <= next_rx;
         rx_cnt   <= rx_push ? 4'h0 : rx_cnt + 4'h1;
      end
   end

   assign rx_pop = arvalid && arready && araddr == `USP_OFS_RXB
                   && rx_count != 2'h0;

   // two-entry holding buffer, oldest word read first
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rx_mem[0] <= 9'h000;
         rx_mem[1] <= 9'h000;
         wr_idx    <= 1'b0;
         rd_idx    <= 1'b0;
         rx_count  <= 2'h0;
         oerr      <= 1'b0;
      end
      else
      begin
         if (!rsc[`USP_RSC_CONTINUOUS_RECEIVE_ENABLE])
            oerr <= 1'b0;
         if (rx_push && rx_count == `USP_RX_DEPTH)
            oerr <= 1'b1;
         if (rx_push && rx_count != `USP_RX_DEPTH)
         begin
            rx_mem[wr_idx] <= rsc[`USP_RSC_RX9] ? next_rx
                              : {1'b0, next_rx[8:1]};
            wr_idx <= !wr_idx;
         end
         if (rx_pop)
            rd_idx <= !rd_idx;
         rx_count <= rx_count
                     + {1'b0, rx_push && rx_count != `USP_RX_DEPTH}
                     - {1'b0, rx_pop};
      end
   end

   // events: set wins over the write-one clear
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         ev_status <= 2'h0;
      else
      begin
         if (wr_hit && aw_addr == `USP_OFS_IST)
            ev_status <= ev_status & ~w_byte[1:0];
         if (tx_load)
            ev_status[`USP_EV_TX] <= 1'b1;
         if (rx_push && rx_count != `USP_RX_DEPTH)
            ev_status[`USP_EV_RX] <= 1'b1;
      end
   end

   assign irq       = |(ev_status & ev_mask);
   // global enable and vector branch belong to the core
   assign core_wake = core_sleep && irq;

   always_comb
   begin
      rd_val = 8'h00;
      rd_map = 1'b1;
      unique case (araddr)
         `USP_OFS_TSC:
         begin
            rd_val = tsc;
            rd_val[`USP_TSC_SHEMPTY]  = !tx_busy;
            rd_val[`USP_TSC_BUFEMPTY] = !tx_full;
         end
         `USP_OFS_RSC:
         begin
            rd_val = rsc;
            rd_val[`USP_RSC_AVAIL] = (rx_count != 2'h0);
            rd_val[`USP_RSC_OERR]  = oerr;
            // an empty buffer shows no stale ninth bit
            rd_val[`USP_RSC_RX9D]  = (rx_count != 2'h0)
                                     && rx_mem[rd_idx][8];
         end
         `USP_OFS_RXB:  rd_val = rx_mem[rd_idx][7:0];
         `USP_OFS_IST:  rd_val = {6'h00, ev_status};
         `USP_OFS_IMSK: rd_val = {6'h00, ev_mask};
         `USP_OFS_TXB:  rd_val = 8'h00;
         default:       rd_map = 1'b0;
      endcase
   end

   assign arready = !rvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid <= 1'b0;
         rdata  <= 32'h0000_0000;
         rresp  <= `USP_RESP_OKAY;
      end
      else if (arvalid && arready)
      begin
         rvalid <= 1'b1;
         rdata  <= {24'h00_0000, rd_val};
         rresp  <= rd_map ? `USP_RESP_OKAY : `USP_RESP_SLVERR;
      end
      else if (rvalid && rready)
         rvalid <= 1'b0;
   end
endmodule : usp_device

// ---- verif/usp_link_assertions.sv ----
`timescale 1ns/1ps
module usp_link_assertions #(
   parameter int HALF = 4
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ck,
   input wire logic dt_dev_o,
   input wire logic dt_dev_oe,
   input wire logic dt_mst_o,
   input wire logic dt_mst_oe,
   input wire logic dt
);
   logic [7:0] hi_cnt;
   logic [7:0] lo_cnt;
   logic [3:0] rises;

   // cycles already spent high / low before the current one
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         hi_cnt <= 8'h00;
      else
         hi_cnt <= ck ? hi_cnt + 8'h01 : 8'h00;
   end

   // saturates so a long idle gap cannot wrap into a false phase
   always_ff @(posedge aclk)
   begin
      if (!aresetn || ck)
         lo_cnt <= 8'h00;
      else if (lo_cnt != 8'hFF)
         lo_cnt <= lo_cnt + 8'h01;
   end

   // a low gap longer than one phase closes the frame
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         rises <= 4'h0;
      else if (lo_cnt == 8'(HALF + 1))
         rises <= {3'h0, ck};
      else if ($rose(ck))
         rises <= rises + 4'h1;
   end

   default clocking dc @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   bus_conflict_a: assert property (!(dt_dev_oe && dt_mst_oe))
      else $error("both ends drive the data line");
   ck_high_a: assert property ($fell(ck) |-> hi_cnt == 8'(HALF))
      else $error("clock high phase has wrong length");
   ck_max_a: assert property (ck |-> hi_cnt < 8'(HALF))
      else $error("clock stays high too long");
   ck_low_a: assert property ($rose(ck) |-> lo_cnt >= 8'(HALF))
      else $error("clock low phase too short");
   dev_stable_a: assert property (
      ck && $past(ck) && dt_dev_oe |-> $stable(dt_dev_o))
      else $error("device data changed while clock high");
   mst_stable_a: assert property (
      ck && $past(ck) && dt_mst_oe |-> $stable(dt_mst_o))
      else $error("master data changed while clock high");
   bit_count_a: assert property (
      lo_cnt == 8'(HALF + 1) && rises != 4'h0
      |-> rises == 4'h8 || rises == 4'h9)
      else $error("frame length is not 8 or 9 bits");
   line_idle_a: assert property (
      !dt_dev_oe && !dt_mst_oe |-> dt)
      else $error("released data line not high");
endmodule : usp_link_assertions

// ---- verif/testbench.sv ----
`timescale 1ns/1ps
`include "usp_defs.svh"
module testbench;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid, irq, core_wake;
   logic        core_sleep, start, write_mode, nine_bits, busy, done, ck_q;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp;
   usp_pkg::usp_word_t tx_word, rx_word, wire_bits;
   int          miscompares, samples_checked, cycles;

   usp_link_if lnk_if ();
   usp_master #(.HALF(8'h04)) usp_master_i (.aclk, .aresetn,
      .lnk(lnk_if.master), .start, .write_mode, .nine_bits, .tx_word,
      .busy, .done, .rx_word);
   usp_device usp_device_i (.aclk, .aresetn, .awaddr, .awvalid, .awready,
      .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
      .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .core_sleep,
      .irq, .core_wake, .lnk(lnk_if.device));
   usp_link_assertions #(.HALF(4)) usp_link_assertions_i (.aclk, .aresetn,
      .ck(lnk_if.ck), .dt_dev_o(lnk_if.dt_dev_o),
      .dt_dev_oe(lnk_if.dt_dev_oe), .dt_mst_o(lnk_if.dt_mst_o),
      .dt_mst_oe(lnk_if.dt_mst_oe), .dt(lnk_if.dt));

   initial
   begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end

   task stop_test;
      if (miscompares == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : stop_test

   // line bits as seen at each clock rise, newest at the top
   always @(posedge aclk)
   begin
      ck_q <= lnk_if.ck;
      if (lnk_if.ck && !ck_q)
         wire_bits <= {lnk_if.dt, wire_bits[8:1]};
      cycles++;
      if (cycles == 4000)
      begin
         miscompares++;
         stop_test();
      end
   end

   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e)
      begin
         miscompares++;
         $display("BAD %s exp %h got %h", n, e, s);
      end
   endtask : chk

   // each channel is released at the rising edge that takes it
   task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (awvalid && awready)
            awvalid <= 1'b0;
         if (wvalid && wready)
            wvalid <= 1'b0;
      end
      while ((awvalid && !awready) || (wvalid && !wready));
      do @(posedge aclk); while (!bvalid);
      r = bresp;
   endtask : wr

   task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge aclk); while (!rvalid);
      d = rdata;
      r = rresp;
   endtask : rd

   // response code in the top two bits, data below
   task rdc(input string n, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0]  r;
      rd(a, d, r);
      chk(n, {r, d[29:0]}, e);
   endtask : rdc

   task xfer(input logic wm, input logic nb, input usp_pkg::usp_word_t w,
             input usp_pkg::usp_word_t e, input string n);
      start <= 1'b1;
      write_mode <= wm;
      nine_bits <= nb;
      tx_word <= w;
      @(posedge aclk);
      start <= 1'b0;
      do @(negedge aclk); while (!done);
      if (!wm)
         chk(n, nb ? rx_word : {1'b0, rx_word[7:0]}, e);
      chk("wire", nb ? wire_bits : {1'b0, wire_bits[8:1]}, e);
      chk("busy_end", busy, 1'b0);
      // device needs a few cycles to post the word it caught
      repeat (6) @(posedge aclk);
   endtask : xfer

   task t_regs;
      logic [1:0] r;
      rdc("rsc_reset", `USP_OFS_RSC, 32'h0);
      rdc("txb_read", `USP_OFS_TXB, 32'h0);
      rdc("unmapped_rd", 8'h3C, 32'h8000_0000);
      wr(8'h3C, 32'h0, r);
      chk("unmapped_wr", r, 2'h2);
   endtask : t_regs

   task t_tx;
      logic [1:0] r;
      wr(`USP_OFS_RSC, 32'h80, r);
      chk("rsc_wr_ok", r, 2'h0);
      wr(`USP_OFS_IMSK, 32'h1, r);
      wr(`USP_OFS_TSC, 32'h71, r);
      wr(`USP_OFS_TXB, 32'hA5, r);
      wr(`USP_OFS_TSC, 32'h70, r);
      wr(`USP_OFS_TXB, 32'h3C, r);
      wr(`USP_OFS_IST, 32'h3, r);
      rdc("buf_full", `USP_OFS_TSC, 32'h70);
      chk("irq_full", irq, 1'b0);
      xfer(1'b0, 1'b1, 9'h0, 9'h1A5, "tx_first");
      do @(negedge aclk); while (irq !== 1'b1);
      @(posedge aclk);
      chk("tx_wake", core_wake, 1'b1);
      rdc("buf_empty", `USP_OFS_TSC, 32'h72);
      xfer(1'b0, 1'b1, 9'h0, 9'h03C, "tx_second");
      wr(`USP_OFS_TSC, 32'hB0, r);
      wr(`USP_OFS_TXB, 32'h55, r);
      xfer(1'b0, 1'b0, 9'h0, 9'h0FF, "tx_master_src");
   endtask : t_tx

   task t_rx;
      logic [1:0] r;
      wr(`USP_OFS_TSC, 32'h10, r);
      wr(`USP_OFS_IST, 32'h3, r);
      wr(`USP_OFS_IMSK, 32'h2, r);
      wr(`USP_OFS_RSC, 32'hF0, r);
      chk("irq_idle", irq, 1'b0);
      xfer(1'b1, 1'b1, 9'h1C3, 9'h1C3, "rx_a");
      chk("rx_irq", irq, 1'b1);
      chk("rx_wake", core_wake, 1'b1);
      rdc("rx_stat", `USP_OFS_RSC, 32'hF5);
      xfer(1'b1, 1'b1, 9'h02E, 9'h02E, "rx_b");
      xfer(1'b1, 1'b1, 9'h111, 9'h111, "rx_c");
      rdc("overrun", `USP_OFS_RSC, 32'hF7);
      rdc("rx_oldest", `USP_OFS_RXB, 32'hC3);
      rdc("rx_next", `USP_OFS_RXB, 32'h2E);
      rdc("err_kept", `USP_OFS_RSC, 32'hF2);
      wr(`USP_OFS_RSC, 32'hE0, r);
      rdc("err_clear", `USP_OFS_RSC, 32'hE0);
   endtask : t_rx

   initial
   begin
      {aresetn, awvalid, wvalid, arvalid, start, write_mode} = 6'h0;
      {awaddr, araddr, wdata, nine_bits, tx_word} = 58'h0;
      {bready, rready, core_sleep} = 3'h7;
      wstrb = 4'hF;
      // the core sleeps throughout: every transfer must run regardless
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs();
      t_tx();
      t_rx();
      stop_test();
   end
endmodule : testbench
